//--- hw/mbc_pkg.sv
/*
 * Shared constants and types of the motor bridge control block.
 * Assumes a 20 MHz clock and comparator flags from the analog power stage.
 */
// How it works
// - Two drive inputs select standby, reverse, forward or brake switch patterns.
// - Undriven drive inputs read low through a permanent pull-down.
// - Standby held longer than 10ms enters sleep with outputs kept floating.
// - Sleep turns off every block but the input synchronisers and wake decode, protection included.
// - Either drive input going high leaves sleep at once.
// - Supply lockout floats both outputs and ignores the drive inputs.
// - Over-current lasting beyond the de-glitch time turns all switches off.
// - After over-current shutdown the retry time expires, then drive resumes.
// - Short circuit turns switches off at once, re-checked every retry period.
// - Over-temperature turns switches off until the recovery level is reached.
// - Lockout and current guards act outside standby; temperature guard acts in every mode but sleep.
package mbc_pkg;

	localparam int CLK_HZ = 20000000;

	// Sleep entry delay in microseconds and its cycle count (least time, clock MHz rounded down).
	localparam int SLEEP_DELAY_US = 10000;
	localparam int SLEEP_CYCLES   = (SLEEP_DELAY_US * (CLK_HZ / 1000000));

	// De-glitch and retry times in microseconds; their values are free parameters.
	localparam int DEGLITCH_US   = 10;
	localparam int DEGLITCH_CYC  = (DEGLITCH_US * (CLK_HZ / 1000000));
	localparam int RETRY_US      = 1000;
	localparam int RETRY_CYCLES  = (RETRY_US * (CLK_HZ / 1000000));

	// Bridge operation modes.
	typedef enum logic [1:0] {
		MBC_STANDBY,
		MBC_REVERSE,
		MBC_FORWARD,
		MBC_BRAKE
	} mbc_mode_e;

	// Four power switch gate commands.
	typedef struct packed {
		logic highSwitchA;
		logic lowSwitchA;
		logic highSwitchB;
		logic lowSwitchB;
	} mbc_switch_s;

	// Analog comparator flags.
	typedef struct packed {
		logic supplyLockout;
		logic overcurrentGuard;
		logic shortCircuitGuard;
		logic tempOver;
		logic tempBelowRecovery;
	} mbc_flags_s;

	localparam mbc_switch_s SW_ALL_OFF = 4'h0;

	// Decode the two drive inputs into a mode.
	function automatic mbc_mode_e mbc_decode(input logic a, input logic b);
		case ({a, b})
			2'b00: mbc_decode = MBC_STANDBY;
			2'b01: mbc_decode = MBC_REVERSE;
			2'b10: mbc_decode = MBC_FORWARD;
			default: mbc_decode = MBC_BRAKE;
		endcase
	endfunction : mbc_decode

endpackage : mbc_pkg

//--- hw/mbc_sync.sv
/*
 * Two-flop synchroniser for a bus of asynchronous inputs.
 * Assumes inputs change slowly compared to the clock.
 */
`timescale 1ns/1ps
`default_nettype none
module mbc_sync #(
	parameter int WIDTH = 2
) (
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             rst,
	// Asynchronous in, synchronous out.
	input  wire logic [WIDTH-1:0] asyncIn,
	output var  logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1_ff;

	// First stage feeds only the second stage.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1_ff <= '0;
			syncOut   <= '0;
		end else begin
			stage1_ff <= asyncIn;
			syncOut   <= stage1_ff;
		end
	end
endmodule : mbc_sync
`default_nettype wire

//--- hw/mbc_timer.sv
/*
 * Down-counter that pulses done after a loaded number of cycles.
 * Assumes start and clear come from the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module mbc_timer #(
	parameter int W = 18
) (
	// Clock and reset.
	input  wire logic         clk,
	input  wire logic         rst,
	// Control.
	input  wire logic         start,
	input  wire logic         clear,
	input  wire logic [W-1:0] loadVal,
	// Status.
	output logic              running,
	output logic              done
);
	logic [W-1:0] count_ff;
	logic         run_ff;

	assign running = run_ff;
	assign done    = run_ff && (count_ff == '0);

	// Load on start, count down, stop at zero or on clear.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_ff <= '0;
			run_ff   <= 1'b0;
		end else if (clear) begin
			run_ff <= 1'b0;
		end else if (start) begin
			count_ff <= loadVal;
			run_ff   <= 1'b1;
		end else if (done) begin
			run_ff <= 1'b0;
		end else if (run_ff) begin
			count_ff <= count_ff - W'(1);
		end
	end
endmodule : mbc_timer
`default_nettype wire

//--- hw/mbc_bridge.sv
/*
 * Control and protection logic of a one-channel motor bridge driver.
 * Assumes drive inputs and comparator flags are asynchronous pins.
 */
`timescale 1ns/1ps
`default_nettype none
module mbc_bridge
	import mbc_pkg::*;
#(
	parameter int SLEEP_CNT = SLEEP_CYCLES,
	parameter int DEG_CNT   = DEGLITCH_CYC,
	parameter int RETRY_CNT = RETRY_CYCLES
) (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst,
	// Drive inputs from the timer outputs.
	input  wire logic        driveInA,
	input  wire logic        driveInB,
	// Analog comparator flags.
	input  wire mbc_flags_s  flags,
	// Bridge outputs: output enable low while driven.
	output logic             bridgeOutA,
	output logic             bridgeOutAOe_n,
	output logic             bridgeOutB,
	output logic             bridgeOutBOe_n,
	// Switch gates and status.
	output mbc_switch_s      switches,
	output logic             sleeping,
	output logic             faultOff
);
	localparam int TW = 18;

	typedef enum logic [1:0] {
		PROT_OK,
		PROT_DEGLITCH,
		PROT_RETRY
	} mbc_prot_e;

	logic [1:0]  inSync;
	mbc_flags_s  flagSync;
	logic        pullA;
	logic        pullB;
	mbc_mode_e   mode;
	logic        isStandby;
	logic        guardsOn;
	logic        lockout;
	logic        ocNow;
	logic        scNow;
	logic        tempOff_ff;
	logic        nxt_tempOff;
	logic        sleep_ff;
	logic        nxt_sleep;
	logic [23:0] stbyCnt_ff;
	logic        stbyDone;
	mbc_prot_e   prot_ff;
	mbc_prot_e   nxt_prot;
	logic [TW-1:0] protLoad;
	logic        protDone;
	logic        protStart;
	logic        protClear;
	mbc_switch_s sw;
	logic        nxt_floatA;
	logic        nxt_floatB;

	// Inputs pull low: a floating pin, carried through the synchroniser, reads as low.
	assign pullA = (inSync[1] === 1'b1);
	assign pullB = (inSync[0] === 1'b1);

	// Pins pass two flip-flops before use.
	mbc_sync #(.WIDTH(2)) uSyncIn (
		.clk     (clk),
		.rst     (rst),
		.asyncIn ({driveInA, driveInB}),
		.syncOut (inSync)
	);
	mbc_sync #(.WIDTH(5)) uSyncFlag (
		.clk     (clk),
		.rst     (rst),
		.asyncIn (flags),
		.syncOut (flagSync)
	);

	assign mode      = mbc_decode(pullA, pullB);
	assign isStandby = (mode == MBC_STANDBY);
	// Current and lockout guards only outside standby.
	assign guardsOn  = !sleep_ff && !isStandby;
	assign lockout   = guardsOn && flagSync.supplyLockout;
	assign ocNow     = guardsOn && flagSync.overcurrentGuard;
	assign scNow     = guardsOn && flagSync.shortCircuitGuard;

	// Temperature hysteresis, acting in every mode but sleep.
	always_comb begin
		nxt_tempOff = tempOff_ff;
		if (sleep_ff)
			nxt_tempOff = 1'b0;
		else if (flagSync.tempOver)
			nxt_tempOff = 1'b1;
		else if (flagSync.tempBelowRecovery)
			nxt_tempOff = 1'b0;
	end

	assign stbyDone = (stbyCnt_ff >= 24'(SLEEP_CNT));

	// Wake on any high input; enter after long standby.
	always_comb begin
		nxt_sleep = sleep_ff;
		if (!isStandby)
			nxt_sleep = 1'b0;
		else if (stbyDone)
			nxt_sleep = 1'b1;
	end

	// Counter restart on any high input.
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			stbyCnt_ff <= '0;
		else if (!isStandby)
			stbyCnt_ff <= '0;
		else if (!stbyDone)
			stbyCnt_ff <= stbyCnt_ff + 24'h1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sleep_ff   <= 1'b0;
			tempOff_ff <= 1'b0;
		end else begin
			sleep_ff   <= nxt_sleep;
			tempOff_ff <= nxt_tempOff;
		end
	end

	// Shared protection timer: de-glitch and retry.
	mbc_timer #(.W(TW)) uTimer (
		.clk     (clk),
		.rst     (rst),
		.start   (protStart),
		.clear   (protClear),
		.loadVal (protLoad),
		.running (),
		.done    (protDone)
	);

	// Retry load select: a short skips de-glitch and loads a full retry.
	assign protLoad  = (nxt_prot == PROT_DEGLITCH) ? TW'(DEG_CNT - 1) : TW'(RETRY_CNT - 1);
	// De-glitch abort: a brief over-current leaves no stale expiry behind.
	assign protClear = (prot_ff == PROT_DEGLITCH) && !ocNow && !scNow;

	// De-glitch then shut. Short circuit skips de-glitch.
	always_comb begin
		nxt_prot  = prot_ff;
		protStart = 1'b0;
		case (prot_ff)
			PROT_OK: begin
				if (scNow) begin
					nxt_prot  = PROT_RETRY;
					protStart = 1'b1;
				end else if (ocNow) begin
					nxt_prot  = PROT_DEGLITCH;
					protStart = 1'b1;
				end
			end
			PROT_DEGLITCH: begin
				if (scNow) begin
					nxt_prot  = PROT_RETRY;
					protStart = 1'b1;
				end else if (!ocNow) begin
					nxt_prot = PROT_OK;
				end else if (protDone) begin
					nxt_prot  = PROT_RETRY;
					protStart = 1'b1;
				end
			end
			PROT_RETRY: begin
				if (protDone)
					nxt_prot = PROT_OK;
			end
			default: nxt_prot = PROT_OK;
		endcase
	end

	// Protection state register.
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			prot_ff <= PROT_OK;
		else
			prot_ff <= nxt_prot;
	end

	assign faultOff = (prot_ff == PROT_RETRY) || tempOff_ff || lockout;

	always_comb begin
		sw = SW_ALL_OFF;
		case (mode)
			MBC_REVERSE: sw = '{1'b0, 1'b1, 1'b1, 1'b0};
			MBC_FORWARD: sw = '{1'b1, 1'b0, 1'b0, 1'b1};
			MBC_BRAKE:   sw = '{1'b0, 1'b1, 1'b0, 1'b1};
			default:     sw = SW_ALL_OFF;
		endcase
		if (faultOff || sleep_ff)
			sw = SW_ALL_OFF;
	end

	assign nxt_floatA = !(sw.highSwitchA || sw.lowSwitchA);
	assign nxt_floatB = !(sw.highSwitchB || sw.lowSwitchB);

	// Registered outputs.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			switches       <= SW_ALL_OFF;
			bridgeOutA     <= 1'b0;
			bridgeOutB     <= 1'b0;
			bridgeOutAOe_n <= 1'b1;
			bridgeOutBOe_n <= 1'b1;
			sleeping       <= 1'b0;
		end else begin
			switches       <= sw;
			bridgeOutA     <= sw.highSwitchA;
			bridgeOutB     <= sw.highSwitchB;
			bridgeOutAOe_n <= nxt_floatA;
			bridgeOutBOe_n <= nxt_floatB;
			sleeping       <= sleep_ff;
		end
	end

	// Forward drives A high, B low.
	a_forward_pattern: assert property (@(posedge clk) disable iff (rst)
		(mode == MBC_FORWARD && !faultOff && !sleep_ff) |=> switches == 4'h9)
		else $error("Forward pattern wrong.");
	a_sleep_entry: assert property (@(posedge clk) disable iff (rst)
		(isStandby && stbyDone && !sleep_ff) |=> sleep_ff)
		else $error("Sleep not entered.");
	a_wake_up: assert property (@(posedge clk) disable iff (rst)
		(sleep_ff && !isStandby) |=> !sleep_ff)
		else $error("Wake missed.");
	a_sleep_off: assert property (@(posedge clk) disable iff (rst)
		sleep_ff |=> switches == SW_ALL_OFF)
		else $error("Switch on in sleep.");
	a_lockout_float: assert property (@(posedge clk) disable iff (rst)
		lockout |=> bridgeOutAOe_n && bridgeOutBOe_n)
		else $error("Output driven in lockout.");
	// Short circuit enters retry at once.
	a_short_off: assert property (@(posedge clk) disable iff (rst)
		(scNow && prot_ff != PROT_RETRY) |=> s_retry_entered ##1 s_all_off)
		else $error("Short not handled.");
	// Steps of a shutdown: the retry state is entered, then every switch is off.
	sequence s_retry_entered;
		prot_ff == PROT_RETRY;
	endsequence
	sequence s_all_off;
		switches == SW_ALL_OFF;
	endsequence

	// Brief over-current does not shut down.
	a_oc_glitch: assert property (@(posedge clk) disable iff (rst)
		(prot_ff == PROT_OK && ocNow && !scNow) |=> prot_ff == PROT_DEGLITCH)
		else $error("De-glitch skipped.");
	a_temp_off: assert property (@(posedge clk) disable iff (rst)
		(tempOff_ff && !flagSync.tempBelowRecovery) |=> switches == SW_ALL_OFF)
		else $error("Switch on when hot.");
	a_count_restart: assert property (@(posedge clk) disable iff (rst)
		!isStandby |=> stbyCnt_ff == '0)
		else $error("Standby count kept.");
	a_retry_release: assert property (@(posedge clk) disable iff (rst)
		(prot_ff == PROT_RETRY && protDone) |=> prot_ff == PROT_OK)
		else $error("Retry not released.");
	// Reverse drives B high, A low.
	a_reverse_pattern: assert property (@(posedge clk) disable iff (rst)
		(mode == MBC_REVERSE && !faultOff && !sleep_ff) |=> switches == 4'h6)
		else $error("Reverse pattern wrong.");
	a_brake_pattern: assert property (@(posedge clk) disable iff (rst)
		(mode == MBC_BRAKE && !faultOff && !sleep_ff) |=> switches == 4'h5
		&& !bridgeOutAOe_n && !bridgeOutBOe_n && !bridgeOutA && !bridgeOutB)
		else $error("Brake pattern wrong.");
	a_standby_float: assert property (@(posedge clk) disable iff (rst)
		isStandby |=> bridgeOutAOe_n && bridgeOutBOe_n)
		else $error("Output driven in standby.");
	a_sleep_guards: assert property (@(posedge clk) disable iff (rst)
		sleep_ff |-> (!lockout && !ocNow && !scNow) ##1 !tempOff_ff)
		else $error("Guard active in sleep.");
	a_oc_shutdown: assert property (@(posedge clk) disable iff (rst)
		(prot_ff == PROT_DEGLITCH && ocNow && !scNow && protDone) |=> s_retry_entered ##1 s_all_off)
		else $error("Over-current not shut down.");
	a_deglitch_abort: assert property (@(posedge clk) disable iff (rst)
		(prot_ff == PROT_DEGLITCH && !ocNow && !scNow) |=> prot_ff == PROT_OK)
		else $error("De-glitch not aborted.");
	a_temp_recover: assert property (@(posedge clk) disable iff (rst)
		(tempOff_ff && flagSync.tempBelowRecovery && !flagSync.tempOver) |=> !tempOff_ff)
		else $error("Temperature shutdown kept.");
	// Temperature guard acts in every mode outside sleep.
	a_temp_any_mode: assert property (@(posedge clk) disable iff (rst)
		(flagSync.tempOver && !sleep_ff) |=> tempOff_ff ##1 s_all_off)
		else $error("Temperature guard idle.");
	// Current and lockout guards idle in standby.
	a_guard_standby: assert property (@(posedge clk) disable iff (rst)
		isStandby |-> !lockout && !ocNow && !scNow)
		else $error("Guard active in standby.");
endmodule : mbc_bridge
`default_nettype wire

//--- test/mbc_mcu_model.sv
/*
 * Controller model: two timer output lines that feed the bridge drive inputs.
 * Assumes the bench supplies the commanded levels and the port direction.
 */
`timescale 1ns/1ps
`default_nettype none
module mbc_mcu_model (
	// Port direction and commanded levels.
	input  wire logic outEn,
	input  wire logic cmdA,
	input  wire logic cmdB,
	// Lines to the drive inputs.
	output wire logic driveA,
	output wire logic driveB
);
	// lines set as outputs
	// The lines drive only when set up as outputs; otherwise they are released.
	assign driveA = outEn ? cmdA : 1'bz;
	assign driveB = outEn ? cmdB : 1'bz;
endmodule : mbc_mcu_model
`default_nettype wire

//--- test/tb_top.sv
/*
 * Self-checking bench for the motor bridge control block.
 * Assumes the controller model drives the inputs and shortened counts.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import mbc_pkg::*;
;
	localparam int SLP = 50;
	localparam int DEG = 5;
	localparam int RTY = 20;
	logic        clk;
	logic        rst;
	logic        outEn;
	logic        cmdA;
	logic        cmdB;
	mbc_flags_s  flg;
	wire logic   driveA;
	wire logic   driveB;
	logic        outA;
	logic        oeA_n;
	logic        outB;
	logic        oeB_n;
	mbc_switch_s sw;
	logic        sleeping;
	logic        faultOff;
	int          n_errors;
	int          check_count;
	// Observed word: sleep, fault, switches, enables, levels.
	wire logic [9:0] obs = {sleeping, faultOff, sw, oeA_n, oeB_n, outA, outB};

	// Controller and block under test.
	mbc_mcu_model mcu (.outEn(outEn), .cmdA(cmdA), .cmdB(cmdB), .driveA(driveA),
		.driveB(driveB));
	mbc_bridge #(.SLEEP_CNT(SLP), .DEG_CNT(DEG), .RETRY_CNT(RTY)) dut (.clk(clk),
		.rst(rst), .driveInA(driveA), .driveInB(driveB), .flags(flg),
		.bridgeOutA(outA), .bridgeOutAOe_n(oeA_n), .bridgeOutB(outB),
		.bridgeOutBOe_n(oeB_n), .switches(sw), .sleeping(sleeping),
		.faultOff(faultOff));

	// Compares one value and counts it.
	task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Sets inputs at an edge, then waits n edges and settles.
	task automatic drive(input logic en, input logic a, input logic b,
		input logic [4:0] f, input int n);
		@(posedge clk);
		outEn <= en;
		cmdA <= a;
		cmdB <= b;
		flg <= f;
		repeat (n) @(posedge clk);
		#1;
	endtask : drive

	// Waits a bounded number of edges for the masked word.
	task automatic waitFor(input logic [9:0] exp, input logic [9:0] m, input int lim,
		output int n);
		n = 0;
		while ((obs & m) !== exp && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask : waitFor

	// Prints the counts and the verdict, then stops.
	task automatic results;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results

	// All four codes, then a released line pair.
	task automatic t_decode;
		logic [9:0] exp [4] = '{10'h00c, 10'h061, 10'h092, 10'h050};
		for (int i = 0; i < 4; i++) begin
			drive(1'b1, i[1], i[0], 5'h00, 4);
			chk(obs, exp[i]);
		end
		drive(1'b0, 1'b1, 1'b1, 5'h00, 4);
		chk(obs, 10'h00c);
		$display("test decode done");
	endtask : t_decode

	// Interrupted standby, real sleep, guards off, then wake.
	task automatic t_sleep;
		int n;
		drive(1'b1, 1'b0, 1'b0, 5'h00, SLP - 10);
		drive(1'b1, 1'b1, 1'b0, 5'h00, 1);
		drive(1'b1, 1'b0, 1'b0, 5'h00, SLP - 10);
		chk(obs, 10'h00c);
		waitFor(10'h20c, 10'h3ff, 30, n);
		chk(obs, 10'h20c);
		drive(1'b1, 1'b0, 1'b0, 5'h0e, 6);
		chk(obs, 10'h20c);
		drive(1'b1, 1'b0, 1'b0, 5'h00, 2);
		drive(1'b1, 1'b0, 1'b1, 5'h00, 4);
		chk(obs, 10'h061);
		$display("test sleep done");
	endtask : t_sleep

	// Supply lockout floats the outputs whatever the inputs say.
	task automatic t_lock;
		drive(1'b1, 1'b1, 1'b0, 5'h10, 4);
		chk(obs, 10'h10c);
		drive(1'b1, 1'b0, 1'b1, 5'h10, 4);
		chk(obs, 10'h10c);
		drive(1'b1, 1'b1, 1'b0, 5'h00, 4);
		chk(obs, 10'h092);
		$display("test lockout done");
	endtask : t_lock

	// Glitch ignored, held over-current shuts off, retry releases.
	task automatic t_ocp;
		int n;
		drive(1'b1, 1'b1, 1'b0, 5'h08, DEG - 2);
		drive(1'b1, 1'b1, 1'b0, 5'h00, 4);
		chk(obs, 10'h092);
		drive(1'b1, 1'b1, 1'b0, 5'h08, 0);
		waitFor(10'h000, 10'h0f0, DEG + 8, n);
		chk(obs & 10'h0f0, 10'h000);
		chk(10'(n >= DEG), 10'h001);
		drive(1'b1, 1'b1, 1'b0, 5'h00, 0);
		waitFor(10'h090, 10'h0f0, RTY + 8, n);
		chk(obs & 10'h0f0, 10'h090);
		chk(10'(n >= RTY - 6), 10'h001);
		$display("test over-current done");
	endtask : t_ocp

	// Short shuts off at once, is off again after three retry periods while present, then recovers.
	task automatic t_osp;
		int n;
		drive(1'b1, 1'b0, 1'b1, 5'h04, 0);
		waitFor(10'h000, 10'h0f0, 5, n);
		chk(obs & 10'h0f0, 10'h000);
		drive(1'b1, 1'b0, 1'b1, 5'h04, 3 * RTY);
		chk(obs & 10'h0f0, 10'h000);
		drive(1'b1, 1'b0, 1'b1, 5'h00, RTY + 8);
		chk(obs, 10'h061);
		$display("test short done");
	endtask : t_osp

	// Temperature hysteresis, and which guards act in standby.
	task automatic t_otp;
		drive(1'b1, 1'b1, 1'b1, 5'h02, 4);
		chk(obs & 10'h0f0, 10'h000);
		drive(1'b1, 1'b1, 1'b1, 5'h00, RTY + 10);
		chk(obs & 10'h0f0, 10'h000);
		drive(1'b1, 1'b1, 1'b1, 5'h01, 4);
		chk(obs, 10'h050);
		drive(1'b1, 1'b0, 1'b0, 5'h08, DEG + 6);
		chk(obs & 10'h300, 10'h000);
		drive(1'b1, 1'b0, 1'b0, 5'h02, 4);
		chk(obs & 10'h300, 10'h100);
		drive(1'b1, 1'b0, 1'b0, 5'h01, 4);
		$display("test temperature done");
	endtask : t_otp

	// Clock of 50 ns period.
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Reset, then the tests in turn.
	initial begin
		n_errors = 0;
		check_count = 0;
		rst = 1'b1;
		outEn = 1'b1;
		cmdA = 1'b0;
		cmdB = 1'b0;
		flg = '0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_decode();
		t_sleep();
		t_lock();
		t_ocp();
		t_osp();
		t_otp();
		results();
	end

	// Watchdog well beyond the expected run length.
	initial begin
		repeat (5000) @(posedge clk);
		n_errors++;
		results();
	end
endmodule : tb_top
`default_nettype wire
